//--- inc/spc_params.svh
// offsets, field positions, reset values and masks of the port command register block
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

`define SPC_ADDR_W     4
`define SPC_OFF_CMD    4'h4
`define SPC_OFF_EVT    4'h8
`define SPC_OFF_MSK    4'hc

`define SPC_CMD_W      16
`define SPC_CMD_RESET  16'h0000
`define SPC_CMD_WMASK  16'h0547
`define SPC_BIT_IO     0
`define SPC_BIT_MEM    1
`define SPC_BIT_BM     2
`define SPC_BIT_PAR    6
`define SPC_BIT_ERR    8
`define SPC_BIT_INTD   10

`define SPC_EVT_W      3
`define SPC_EVT_RESET  3'h0
`define SPC_MSK_RESET  3'h0
`define SPC_EVT_PAR    0
`define SPC_EVT_SYS    1
`define SPC_EVT_UR     2

`endif

//--- inc/spc_pkg.sv
// types shared by the port command register block
`include "spc_params.svh"
package spc_pkg;

   // one transaction request seen by the port
   typedef struct packed {
      logic valid;
      logic is_io;
      logic posted;
   } spc_req_t;

   // one-cycle decisions of the gating logic
   typedef struct packed {
      logic pri_accept;
      logic pri_ignore;
      logic up_fwd;
      logic ur_cpl;
      logic ur_drop;
      logic par_act;
      logic err_msg;
      logic intx_own;
      logic intx_fwd;
   } spc_gate_out_t;

   // whole state of the gating module
   typedef struct packed {
      spc_gate_out_t gout;
   } spc_gate_st_t;

   // whole state of the register block
   typedef struct packed {
      logic                  ack;
      logic [31:0]           rdata;
      logic [`SPC_CMD_W-1:0] cmd;
      logic [`SPC_EVT_W-1:0] evt;
      logic [`SPC_EVT_W-1:0] msk;
   } spc_regs_t;

endpackage

//--- hdl/spc_gate.sv
// gating of port traffic, error handling and interrupt messages by the command bits
`timescale 1ns/1ps
`include "spc_params.svh"
module spc_gate
   import spc_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   input  wire logic [`SPC_CMD_W-1:0] cmd,
   input  wire spc_req_t              pri_req,
   input  wire spc_req_t              dn_req,
   input  wire logic                  par_err,
   input  wire logic                  err_det,
   input  wire logic                  intx_req,
   input  wire logic                  intx_dn,
   output spc_gate_out_t              gout
);

   spc_gate_st_t st_q;
   spc_gate_st_t st_d;
   logic         pri_en;

   // primary side answers only for the enabled space
   assign pri_en = pri_req.is_io ? cmd[`SPC_BIT_IO] : cmd[`SPC_BIT_MEM];

   // every decision is a registered one-cycle pulse
   always_comb begin
      st_d = '0;
      st_d.gout.pri_accept = pri_req.valid & pri_en;
      st_d.gout.pri_ignore = pri_req.valid & ~pri_en;
      // upstream forwarding needs bus master on
      st_d.gout.up_fwd = dn_req.valid & cmd[`SPC_BIT_BM];
      // rejected non-posted requests get an unsupported request completion
      st_d.gout.ur_cpl = dn_req.valid & ~cmd[`SPC_BIT_BM] & ~dn_req.posted;
      // rejected posted requests have nobody to answer, they are dropped
      st_d.gout.ur_drop = dn_req.valid & ~cmd[`SPC_BIT_BM] & dn_req.posted;
      // parity errors are simply ignored while the response bit is clear
      st_d.gout.par_act = par_err & cmd[`SPC_BIT_PAR];
      st_d.gout.err_msg = err_det & cmd[`SPC_BIT_ERR];
      st_d.gout.intx_own = intx_req & ~cmd[`SPC_BIT_INTD];
      // forwarded messages never look at the disable bit
      st_d.gout.intx_fwd = intx_dn;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign gout = st_q.gout;

endmodule

//--- hdl/spc_top.sv
// command register of one switch port: avalon slave, event flags, interrupt and gating
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
// How it works
// - I/O enable bit 0, clear after reset, decides if primary I/O requests are answered.
// - Memory enable bit 1, clear after reset, gates answers to primary memory requests.
// - Bus master bit 2 clear: no upstream requests, downstream ones are unsupported.
// - Each rejected non-posted downstream request gets an unsupported request completion; ignored primary requests get none.
// - With bus master bit 2 set, memory and I/O requests are forwarded upstream.
// - Parity response bit 6 enables normal parity error handling; clear means ignore.
// - Error reporting bit 8, clear after reset, gates fatal and non-fatal error reports.
// - Interrupt disable bit 10 is writable, resets to zero and blocks the port's own INTx.
// - INTx messages forwarded from below pass whatever interrupt disable says.
// - Bits 3, 4, 5, 7 and 9 are read-only zero and ignore writes.
// - The parity error flag is never set while parity response bit 6 is clear.
// - The system error flag is set when an error message is sent with bit 8 set.
`include "spc_params.svh"
module spc_top
   import spc_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   input  wire logic [`SPC_ADDR_W-1:0] avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest,
   input  wire spc_req_t              pri_req,
   input  wire spc_req_t              dn_req,
   input  wire logic                  par_err,
   input  wire logic                  err_det,
   input  wire logic                  intx_req,
   input  wire logic                  intx_dn,
   output spc_gate_out_t              gout,
   output logic [`SPC_CMD_W-1:0]      cmd_o,
   output logic                       irq
);

   spc_regs_t             st_q;
   spc_regs_t             st_d;
   logic                  req;
   logic                  commit;
   logic [31:0]           wmask;
   logic [31:0]           wbits;
   logic [31:0]           rd_val;
   logic [`SPC_EVT_W-1:0] ev_set;
   logic [`SPC_EVT_W-1:0] ev_clr;
   logic [15:0]           wd_lo;
   logic [31:0]           cmd_mrg;

   // byte enables widened to a bit mask
   function automatic logic [31:0] be_mask(input logic [3:0] be);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{be[i]}};
      end
      return m;
   endfunction

   // register decode of one word offset
   function automatic logic hit(input logic [`SPC_ADDR_W-1:0] a,
                                input logic [`SPC_ADDR_W-1:0] off);
      return a == off;
   endfunction

   // masked merge of write data into a stored value
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [31:0] m);
      return (old & ~m) | (wd & m);
   endfunction

   // bus handshake: one wait cycle, then the request is taken
   assign req             = avs_read | avs_write;
   assign commit          = avs_write & st_q.ack;
   assign avs_waitrequest = req & ~st_q.ack;
   assign avs_readdata    = st_q.rdata;
   assign wmask           = be_mask(avs_byteenable);
   assign wbits           = avs_writedata & wmask;
   assign wd_lo           = avs_writedata[15:0];

   // masked command write; read-only and reserved bits are forced back to zero
   assign cmd_mrg = merge({16'h0, st_q.cmd}, avs_writedata, wmask)
                    & {16'h0, `SPC_CMD_WMASK};

   // read mux; status half of the command dword and unmapped words read zero
   always_comb begin
      rd_val = '0;
      if (hit(avs_address, `SPC_OFF_CMD)) begin
         rd_val[15:0] = st_q.cmd & `SPC_CMD_WMASK;
      end else if (hit(avs_address, `SPC_OFF_EVT)) begin
         rd_val[`SPC_EVT_W-1:0] = st_q.evt;
      end else if (hit(avs_address, `SPC_OFF_MSK)) begin
         rd_val[`SPC_EVT_W-1:0] = st_q.msk;
      end
   end

   // event sources; the parity flag also checks the live enable so that a
   // late clear of bit 6 cannot let one pulse in
   assign ev_set[`SPC_EVT_PAR] = gout.par_act & st_q.cmd[`SPC_BIT_PAR];
   assign ev_set[`SPC_EVT_SYS] = gout.err_msg & st_q.cmd[`SPC_BIT_ERR];
   assign ev_set[`SPC_EVT_UR]  = gout.ur_cpl;
   assign ev_clr = (commit && hit(avs_address, `SPC_OFF_EVT)) ?
                   wbits[`SPC_EVT_W-1:0] : '0;

   // next state of the whole register block
   always_comb begin
      st_d     = st_q;
      st_d.ack = req & ~st_q.ack;
      if (req && !st_q.ack) begin
         st_d.rdata = rd_val;
      end
      if (commit && hit(avs_address, `SPC_OFF_CMD)) begin
         // only the low half holds the command; the upper half is the status half
         st_d.cmd = cmd_mrg[`SPC_CMD_W-1:0];
      end
      if (commit && hit(avs_address, `SPC_OFF_MSK)) begin
         st_d.msk = wbits[`SPC_EVT_W-1:0] |
                    (st_q.msk & ~wmask[`SPC_EVT_W-1:0]);
      end
      // a set in the clearing cycle wins
      st_d.evt = (st_q.evt & ~ev_clr) | ev_set;
   end

   // synchronous reset to the documented clear state
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_q <= '{ack: 1'b0, rdata: 32'h0000_0000, cmd: `SPC_CMD_RESET,
                   evt: `SPC_EVT_RESET, msk: `SPC_MSK_RESET};
      end else begin
         st_q <= st_d;
      end
   end

   assign cmd_o = st_q.cmd;
   // level interrupt, high while any unmasked flag stands
   assign irq   = |(st_q.evt & st_q.msk);

   // gating of the port's traffic by the stored command bits
   spc_gate u_gate (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .cmd      (st_q.cmd),
      .pri_req  (pri_req),
      .dn_req   (dn_req),
      .par_err  (par_err),
      .err_det  (err_det),
      .intx_req (intx_req),
      .intx_dn  (intx_dn),
      .gout     (gout)
   );

   // ---- checks on the bus handshake ----
   sequence s_req_new;
      req && !st_q.ack;
   endsequence

   sequence s_taken;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence

   property p_handshake;
      @(posedge core_clk) disable iff (!rst_n)
      s_req_new |-> s_taken;
   endproperty
   a_handshake: assert property (p_handshake)
      else $error("request not taken after one wait cycle");

   property p_cmd_write;
      @(posedge core_clk) disable iff (!rst_n)
      (commit && hit(avs_address, `SPC_OFF_CMD) && avs_byteenable == 4'hf)
      |=> st_q.cmd == ($past(wd_lo) & `SPC_CMD_WMASK);
   endproperty
   a_cmd_write: assert property (p_cmd_write)
      else $error("command write not stored as masked data");

   property p_cmd_read;
      @(posedge core_clk) disable iff (!rst_n)
      (avs_read && !avs_waitrequest && hit(avs_address, `SPC_OFF_CMD))
      |-> avs_readdata == {16'h0, st_q.cmd};
   endproperty
   a_cmd_read: assert property (p_cmd_read)
      else $error("command read does not show stored bits");

   // ---- checks on the stored command ----
   property p_fixed_zero;
      @(posedge core_clk) disable iff (!rst_n)
      (st_q.cmd & ~`SPC_CMD_WMASK) == 16'h0000;
   endproperty
   a_fixed_zero: assert property (p_fixed_zero)
      else $error("read-only or reserved command bit is set");

   property p_reset_clear;
      @(posedge core_clk) disable iff (!rst_n)
      !$past(rst_n) |-> (st_q.cmd == `SPC_CMD_RESET && st_q.evt == `SPC_EVT_RESET);
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("command or flags not clear after reset");

   // ---- checks on the gating ----
   property p_io_gate;
      @(posedge core_clk) disable iff (!rst_n)
      (pri_req.valid && pri_req.is_io)
      |=> gout.pri_accept == $past(st_q.cmd[`SPC_BIT_IO]);
   endproperty
   a_io_gate: assert property (p_io_gate)
      else $error("I/O request answer does not follow I/O enable");

   property p_mem_gate;
      @(posedge core_clk) disable iff (!rst_n)
      (pri_req.valid && !pri_req.is_io)
      |=> gout.pri_accept != gout.pri_ignore &&
          gout.pri_accept == $past(st_q.cmd[`SPC_BIT_MEM]);
   endproperty
   a_mem_gate: assert property (p_mem_gate)
      else $error("memory request answer does not follow memory enable");

   property p_no_master;
      @(posedge core_clk) disable iff (!rst_n)
      (dn_req.valid && !st_q.cmd[`SPC_BIT_BM]) |=> !gout.up_fwd;
   endproperty
   a_no_master: assert property (p_no_master)
      else $error("request forwarded upstream with bus master off");

   property p_ur_cpl;
      @(posedge core_clk) disable iff (!rst_n)
      (dn_req.valid && !dn_req.posted && !st_q.cmd[`SPC_BIT_BM])
      |=> gout.ur_cpl ##1 st_q.evt[`SPC_EVT_UR];
   endproperty
   a_ur_cpl: assert property (p_ur_cpl)
      else $error("no unsupported request completion or flag");

   property p_forward;
      @(posedge core_clk) disable iff (!rst_n)
      (dn_req.valid && st_q.cmd[`SPC_BIT_BM]) |=> gout.up_fwd && !gout.ur_cpl;
   endproperty
   a_forward: assert property (p_forward)
      else $error("request not forwarded with bus master on");

   property p_parity;
      @(posedge core_clk) disable iff (!rst_n)
      par_err |=> gout.par_act == $past(st_q.cmd[`SPC_BIT_PAR]);
   endproperty
   a_parity: assert property (p_parity)
      else $error("parity handling does not follow response bit");

   property p_par_flag;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(st_q.evt[`SPC_EVT_PAR]) |-> $past(st_q.cmd[`SPC_BIT_PAR]);
   endproperty
   a_par_flag: assert property (p_par_flag)
      else $error("parity flag set while response bit clear");

   property p_err_gate;
      @(posedge core_clk) disable iff (!rst_n)
      (err_det && !st_q.cmd[`SPC_BIT_ERR]) |=> !gout.err_msg;
   endproperty
   a_err_gate: assert property (p_err_gate)
      else $error("error reported with reporting disabled");

   property p_sys_flag;
      @(posedge core_clk) disable iff (!rst_n)
      (err_det && st_q.cmd[`SPC_BIT_ERR] && st_d.cmd[`SPC_BIT_ERR])
      |=> gout.err_msg ##1 st_q.evt[`SPC_EVT_SYS];
   endproperty
   a_sys_flag: assert property (p_sys_flag)
      else $error("system error flag not set after error message");

   property p_intx_own;
      @(posedge core_clk) disable iff (!rst_n)
      intx_req |=> gout.intx_own == !$past(st_q.cmd[`SPC_BIT_INTD]);
   endproperty
   a_intx_own: assert property (p_intx_own)
      else $error("own INTx does not follow interrupt disable");

   property p_intx_fwd;
      @(posedge core_clk) disable iff (!rst_n)
      intx_dn |=> gout.intx_fwd;
   endproperty
   a_intx_fwd: assert property (p_intx_fwd)
      else $error("forwarded INTx was blocked");

   property p_irq_rise;
      @(posedge core_clk) disable iff (!rst_n)
      (|(ev_set & st_q.msk)) |=> irq;
   endproperty
   a_irq_rise: assert property (p_irq_rise)
      else $error("unmasked event did not raise the interrupt");

endmodule

//--- dv/spc_rc_model.sv
// far side model: traffic, faults and interrupts toward the port, and a count of ur completions
`timescale 1ns/1ps
module spc_rc_model
   import spc_pkg::*;
(
   input  wire logic          core_clk,
   input  wire spc_gate_out_t gout,
   output spc_req_t           pri_req,
   output spc_req_t           dn_req,
   output logic               par_err,
   output logic               err_det,
   output logic               intx_req,
   output logic               intx_dn,
   output int                 ur_seen
);
   // everything idle at time zero
   initial begin
      pri_req = '0;
      dn_req = '0;
      {par_err, err_det, intx_req, intx_dn} = 4'h0;
      ur_seen = 0;
   end

   // ur completions returned to the requester below the port
   always @(posedge core_clk) begin
      if (gout.ur_cpl === 1'b1) begin
         ur_seen <= ur_seen + 1;
      end
   end

   // one-cycle pulse of kind k: 0 pri io, 1 pri mem, 2 dn np io, 3 dn posted mem,
   // 4 parity, 5 error, 6 own intx, 7 intx from below
   task automatic send(input int k);
      @(posedge core_clk);
      pri_req <= '{valid: k < 2, is_io: k == 0, posted: 1'b0};
      dn_req <= '{valid: k == 2 || k == 3, is_io: k == 2, posted: k == 3};
      par_err <= k == 4;
      err_det <= k == 5;
      intx_req <= k == 6;
      intx_dn <= k == 7;
      @(posedge core_clk);
      pri_req <= '0;
      dn_req <= '0;
      {par_err, err_det, intx_req, intx_dn} <= 4'h0;
   endtask
endmodule

//--- dv/tb.sv
// self-checking bench for the port command register block
`timescale 1ns/1ps
`include "spc_params.svh"
module tb
   import spc_pkg::*;
;
   logic                   core_clk = 1'b0;
   logic                   rst_n = 1'b0;
   logic [`SPC_ADDR_W-1:0] avs_address = '0;
   logic                   avs_read = 1'b0;
   logic                   avs_write = 1'b0;
   logic [31:0]            avs_writedata = '0;
   logic [3:0]             avs_byteenable = '0;
   logic [3:0]             be = 4'hf;
   logic [31:0]            avs_readdata;
   logic                   avs_waitrequest;
   spc_req_t               pri_req;
   spc_req_t               dn_req;
   logic                   par_err;
   logic                   err_det;
   logic                   intx_req;
   logic                   intx_dn;
   spc_gate_out_t          gout;
   logic [15:0]            cmd_o;
   logic                   irq;
   int                     ur_seen;
   int                     fail_count = 0;
   int                     samples_checked = 0;
   int                     cyc = 0;
   logic [15:0]            cmds [4] = '{16'h0000, 16'h0547, 16'h0042, 16'h0505};
   logic [2:0]             msks [4] = '{3'h0, 3'h3, 3'h4, 3'h7};

   spc_top dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pri_req(pri_req), .dn_req(dn_req),
      .par_err(par_err), .err_det(err_det), .intx_req(intx_req), .intx_dn(intx_dn),
      .gout(gout), .cmd_o(cmd_o), .irq(irq));

   spc_rc_model rc (.core_clk(core_clk), .gout(gout), .pri_req(pri_req), .dn_req(dn_req),
      .par_err(par_err), .err_det(err_det), .intx_req(intx_req), .intx_dn(intx_dn),
      .ur_seen(ur_seen));

   // 125 MHz clock
   always #4 core_clk = ~core_clk;

   // hang guard: the sequence needs well under a thousand cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk_v(input logic [31:0] got, input logic [31:0] e, input string s);
      samples_checked++;
      if (got !== e) begin
         fail_count++;
         $display("[ERR] %0t %s got %h want %h", $time, s, got, e);
      end
   endtask

   task automatic chk_g(input spc_gate_out_t got, input spc_gate_out_t e, input int k);
      samples_checked++;
      if (got !== e) begin
         fail_count++;
         $display("[ERR] %0t gate kind %0d got %b want %b", $time, k, got, e);
      end
   endtask

   // one avalon access; held until a rising edge samples waitrequest low, released there
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      avs_byteenable <= be;
      // no wait count is assumed; only the hang guard ends a stuck access
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e, input string s);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk_v(q, e, s);
   endtask

   // expected one-cycle decision for traffic kind k under command value c
   function automatic spc_gate_out_t exp_g(input logic [15:0] c, input int k);
      spc_gate_out_t g;
      g = '0;
      g.pri_accept = (k == 0 && c[0]) || (k == 1 && c[1]);
      g.pri_ignore = (k == 0 && !c[0]) || (k == 1 && !c[1]);
      g.up_fwd = (k == 2 || k == 3) && c[2];
      g.ur_cpl = k == 2 && !c[2];
      g.ur_drop = k == 3 && !c[2];
      g.par_act = k == 4 && c[6];
      g.err_msg = k == 5 && c[8];
      g.intx_own = k == 6 && !c[10];
      g.intx_fwd = k == 7;
      return g;
   endfunction

   // main sequence
   initial begin
      logic [15:0] c;
      logic [2:0]  ev;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(`SPC_OFF_CMD, 32'h0, "cmd reset");
      rd(`SPC_OFF_EVT, 32'h0, "evt reset");
      rd(`SPC_OFF_MSK, 32'h0, "msk reset");
      wr(4'h0, 32'hffffffff);
      rd(4'h0, 32'h0, "unmapped");
      wr(`SPC_OFF_CMD, 32'hffffffff);
      rd(`SPC_OFF_CMD, 32'h00000547, "cmd fixed bits");
      $display("test access done");
      // every enable bit on and off against every traffic kind, then events and irq
      for (int i = 0; i < 4; i++) begin
         c = cmds[i];
         ev = {~c[2], c[8], c[6]};
         wr(`SPC_OFF_CMD, {16'h0, c});
         @(negedge core_clk);
         chk_v({16'h0, cmd_o}, {16'h0, c}, "cmd_o");
         for (int k = 0; k < 8; k++) begin
            rc.send(k);
            @(negedge core_clk);
            chk_g(gout, exp_g(c, k), k);
         end
         rd(`SPC_OFF_EVT, {29'h0, ev}, "events");
         wr(`SPC_OFF_MSK, {29'h0, msks[i]});
         @(negedge core_clk);
         chk_v({31'h0, irq}, {31'h0, |(ev & msks[i])}, "irq raised");
         wr(`SPC_OFF_EVT, 32'h7);
         @(negedge core_clk);
         chk_v({31'h0, irq}, 32'h0, "irq cleared");
         rd(`SPC_OFF_EVT, 32'h0, "evt cleared");
      end
      chk_v(ur_seen, 32'h2, "ur completions");
      $display("test gating done");
      // byte lanes: lane 1 alone, then lane 0 alone
      be = 4'h2;
      wr(`SPC_OFF_CMD, 32'h0);
      rd(`SPC_OFF_CMD, 32'h00000005, "lane1 write");
      be = 4'h1;
      wr(`SPC_OFF_CMD, 32'hffffffff);
      rd(`SPC_OFF_CMD, 32'h00000047, "lane0 write");
      be = 4'hf;
      $display("test lanes done");
      // pending event through a second reset; bit 6 is still set, so parity raises a flag
      rc.send(4);
      @(negedge core_clk);
      chk_v({31'h0, irq}, 32'h0, "irq late");
      @(negedge core_clk);
      chk_v({31'h0, irq}, 32'h1, "irq pending");
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk_v({15'h0, irq, cmd_o}, 32'h0, "second reset");
      @(posedge core_clk);
      rst_n <= 1'b1;
      rd(`SPC_OFF_EVT, 32'h0, "evt after reset");
      $display("test reset done");
      close_out();
   end
endmodule
